// File: common/osc_pkg.sv
// Constants and types of the serial control register bank.
// Assumes a single 25 MHz core clock that samples the serial link pins.
`default_nettype none

package osc_pkg;
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned CNT_W = 6;
  localparam int unsigned CHANNELS = 8;
  localparam logic [2:0] FRAME_LEN_CODE = 3'h2;
  localparam logic [1:0] INTEGRITY_CHECK_CODE = 2'h1;
  localparam logic MULTI_READ_SUPPORT = 1'b1;
  localparam logic [7:0] SERIAL_CAPABILITY =
    {MULTI_READ_SUPPORT, FRAME_LEN_CODE, 2'h0, INTEGRITY_CHECK_CODE};
  localparam logic [5:0] ROM_ADDR_CAPABILITY = 6'h10;

  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_READ_CLEAR = 2'h2;
  localparam logic [1:0] OP_ROM_READ = 2'h3;

  localparam logic [6:0] ADDR_PAGE = 7'h00;
  localparam logic [6:0] ADDR_PAGE_MIRROR = 7'h40;
  localparam logic [6:0] ADDR_MODE = 7'h01;
  localparam logic [6:0] ADDR_SELFTEST = 7'h02;
  localparam logic [6:0] ADDR_OUTPUT = 7'h03;
  localparam logic [6:0] ADDR_PAIR01 = 7'h04;
  localparam logic [6:0] ADDR_PAIR67 = 7'h07;

  localparam int unsigned BIT_PARITY = 0;
  localparam int unsigned BIT_WDT = 1;
  localparam int unsigned BIT_PAGE = 2;
  localparam int unsigned BIT_UNLOCK = 3;
  localparam int unsigned BIT_CONV_TEST = 4;
  localparam int unsigned BIT_SENSE_TEST = 5;
  localparam int unsigned BIT_SHADOW_TEST = 6;
  localparam int unsigned BIT_STUCK_LO = 8;
  localparam int unsigned BIT_NORMAL = 14;
  localparam int unsigned BIT_GO_LOW_POWER = 15;
  localparam int unsigned BIT_OUT_LO = 8;
  // Pair layout: odd channel field = even channel field + ODD_SHIFT
  localparam int unsigned ODD_SHIFT = 7;
  localparam int unsigned EVEN_DIN = 8;
  localparam int unsigned EVEN_ENTER = 7;
  localparam int unsigned EVEN_LEAVE = 6;
  localparam int unsigned EVEN_LIMIT_LO = 4;
  localparam int unsigned EVEN_FINE = 2;

  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [0:0] {
    OSC_IDLE = 1'b0,
    OSC_SHIFT = 1'b1
  } osc_frame_st_t;
endpackage : osc_pkg

`default_nettype wire

// File: sim/osc_ctrl_regs_asserts.sv
// Port checks for the serial control register bank.
// Assumes mclk_i samples all pins; bound into every osc_ctrl_regs.
`default_nettype none

module osc_ctrl_regs_asserts (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic csn_i,
  input wire logic sdo_oe_o,
  input wire logic spi_error_o,
  input wire logic normal_mode_o,
  input wire logic go_low_power_o,
  input wire logic shadow_mem_selftest_go_o,
  input wire logic [osc_pkg::CHANNELS-1:0] chan_output_on_o,
  input wire logic [osc_pkg::CHANNELS-1:0] charge_mode_enter_o,
  input wire logic [osc_pkg::CHANNELS-1:0] charge_mode_leave_o,
  input wire logic [osc_pkg::CHANNELS-1:0] capacitive_charge_state_o
);
  import osc_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Last non-zero pulses, so a one-cycle lag of the state is tolerated
  logic [CHANNELS-1:0] ent_q, lev_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ent_q <= '0;
      lev_q <= '0;
    end else begin
      ent_q <= (charge_mode_enter_o != '0) ? charge_mode_enter_o : ent_q;
      lev_q <= (charge_mode_leave_o != '0) ? charge_mode_leave_o : lev_q;
    end
  end
  a_oe_idle_off: assert property (csn_i [*8] |-> !sdo_oe_o)
    else $error("answer enable high while deselected");
  a_oe_on_select: assert property ($fell(csn_i) |-> ##[2:7] sdo_oe_o)
    else $error("answer enable late after select");
  a_out_at_end: assert property (!$stable(chan_output_on_o) |-> csn_i)
    else $error("output enables changed inside a frame");
  a_error_at_end: assert property ($changed(spi_error_o) |-> csn_i)
    else $error("error flag changed inside a frame");
  a_test_pulse: assert property (shadow_mem_selftest_go_o |=>
    !shadow_mem_selftest_go_o) else $error("self-test pulse too long");
  a_enter_pulse: assert property (charge_mode_enter_o != '0 |=>
    charge_mode_enter_o == '0) else $error("charge entry pulse too long");
  a_enter_normal: assert property (charge_mode_enter_o != '0 |->
    normal_mode_o) else $error("charge entry outside normal mode");
  a_enter_sets: assert property (charge_mode_enter_o != '0 |-> ##[1:2]
    (capacitive_charge_state_o & ent_q) == ent_q)
    else $error("charge state not set by entry");
  a_leave_clears: assert property (charge_mode_leave_o != '0 &&
    charge_mode_enter_o == '0 |-> ##[1:2]
    (capacitive_charge_state_o & lev_q) == '0)
    else $error("charge state not cleared by exit");
  a_standby_normal: assert property ($rose(go_low_power_o) |->
    $past(normal_mode_o)) else $error("low power entered from fail-safe");
  c_normal: cover property ($rose(normal_mode_o));
  c_error: cover property ($rose(spi_error_o));
  c_charge: cover property (charge_mode_enter_o != '0);
  c_standby: cover property ($rose(go_low_power_o));
endmodule : osc_ctrl_regs_asserts

bind osc_ctrl_regs osc_ctrl_regs_asserts u_chk (.mclk_i, .rst_i, .csn_i,
  .sdo_oe_o, .spi_error_o, .normal_mode_o, .go_low_power_o,
  .shadow_mem_selftest_go_o, .chan_output_on_o, .charge_mode_enter_o,
  .charge_mode_leave_o, .capacitive_charge_state_o);

`default_nettype wire

// File: sim/osc_ctrl_regs_tb_top.sv
// Self-checking bench for the serial control register bank.
// Assumes the master model and the bound checker are compiled alongside.
`default_nettype none

module osc_ctrl_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import osc_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sck_i, csn_i, sdi_i, sdo_o, sdo_oe_o, spi_error_o, normal_mode_o;
  logic go_low_power_o, active_page_sel_o, watchdog_flip_bit_o;
  logic shadow_mem_selftest_go_o, sense_chain_selftest_go_o;
  logic converter_selftest_go_o, clr = 1'b0;
  logic [CHANNELS-1:0] switch_stuck_selftest_go_o, chan_output_on_o;
  logic [CHANNELS-1:0] direct_pin_ctrl_on_o, charge_mode_enter_o;
  logic [CHANNELS-1:0] charge_mode_leave_o, capacitive_charge_state_o;
  logic [CHANNELS-1:0] fine_sense_range_o;
  logic [2*CHANNELS-1:0] current_limit_sel_o;
  logic [18:0] seen = '0;
  logic [23:0] rx;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  osc_ctrl_regs dut (.mclk_i, .rst_i, .sck_i, .csn_i, .sdi_i, .sdo_o,
    .sdo_oe_o, .spi_error_o, .normal_mode_o, .go_low_power_o,
    .active_page_sel_o, .watchdog_flip_bit_o, .switch_stuck_selftest_go_o,
    .shadow_mem_selftest_go_o, .sense_chain_selftest_go_o,
    .converter_selftest_go_o, .chan_output_on_o, .direct_pin_ctrl_on_o,
    .charge_mode_enter_o, .charge_mode_leave_o, .capacitive_charge_state_o,
    .current_limit_sel_o, .fine_sense_range_o);
  osc_spi_master m (.sck_o(sck_i), .csn_o(csn_i), .sdi_o(sdi_i),
    .sdo_i(sdo_o));
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  // Pulses last one cycle, so they are collected here between checks
  always @(posedge mclk_i) begin
    seen <= clr ? 19'h0 : seen | {shadow_mem_selftest_go_o,
      sense_chain_selftest_go_o, converter_selftest_go_o,
      charge_mode_enter_o, charge_mode_leave_o};
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  function automatic logic [23:0] mk(logic [1:0] op, logic [5:0] a,
                                     logic [15:0] d);
    logic [23:0] f;
    f = {op, a, d[15:1], 1'b0};
    f[0] = ~^f[23:1];
    return f;
  endfunction : mk
  task automatic chk(input string n, input logic [23:0] e,
                     input logic [23:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    m.xfer(mk(OP_WRITE, a[5:0], d), 24, rx);
  endtask : wr
  task automatic rd(input logic [6:0] a);
    m.xfer(mk(OP_READ, a[5:0], 16'h0), 24, rx);
    chk("answer parity", 24'h1, {23'h0, ^rx});
  endtask : rd
  task automatic clr_seen;
    clr <= 1'b1;
    @(posedge mclk_i);
    clr <= 1'b0;
  endtask : clr_seen
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    logic [15:0] w;
    logic [23:0] f;
    logic [7:0] e;
    int p;
    void'($urandom(34));
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    chk("reset", 24'h0, {chan_output_on_o, current_limit_sel_o});
    m.xfer(mk(OP_ROM_READ, ROM_ADDR_CAPABILITY, 16'h0), 24, rx);
    chk("capability", {1'b1, 3'b010, 4'b0001}, rx[15:8]);
    repeat (4) begin
      w = 16'($urandom());
      wr(ADDR_OUTPUT, w);
      chk("outputs", {w[15:8], w[1]}, {chan_output_on_o, watchdog_flip_bit_o});
      rd(ADDR_OUTPUT);
      chk("output readback", w & 16'hff02, {rx[15:1], 1'b0});
    end
    // Read-clear on a control register must leave its contents alone
    m.xfer(mk(OP_READ_CLEAR, ADDR_OUTPUT[5:0], 16'h0), 24, rx);
    chk("read clear answer", w & 16'hff02, {rx[15:1], 1'b0});
    chk("read clear keeps", {w[15:8], w[1]}, {chan_output_on_o, watchdog_flip_bit_o});
    for (p = 0; p < 4; p++) begin
      w = 16'($urandom());
      wr(7'(ADDR_PAIR01 + p), w);
      chk("pair fields", {w[15], w[8], w[12:11], w[5:4], w[9], w[2]}, {direct_pin_ctrl_on_o[2*p+1], direct_pin_ctrl_on_o[2*p], current_limit_sel_o[4*p+:4], fine_sense_range_o[2*p+1], fine_sense_range_o[2*p]});
      rd(7'(ADDR_PAIR01 + p));
      chk("pair readback", w & 16'h9b36, {rx[15:1], 1'b0});
    end
    $display("register map test done");
    wr(ADDR_OUTPUT, 16'h0f00);
    for (int k = 0; k < 3; k++) begin
      f = mk(OP_WRITE, ADDR_OUTPUT[5:0], 16'hf000);
      f[0] = f[0] ^ (k == 2);
      m.xfer(f, (k == 2) ? 24 : 23 + 2 * k, rx);
      chk("bad frame", 24'h10f, {15'h0, spi_error_o, chan_output_on_o});
    end
    rd(ADDR_OUTPUT);
    chk("error clear", 24'h2, {22'h0, rx[23], spi_error_o});
    $display("frame error test done");
    w = {8'($urandom()), 8'h70};
    clr_seen();
    wr(ADDR_SELFTEST, w);
    chk("selftest", {w[15:8], 3'b111}, {switch_stuck_selftest_go_o, seen[18:16]});
    rd(ADDR_SELFTEST);
    chk("selftest readback", {w[15:8], 3'b000}, {rx[15:8], rx[6:4]});
    $display("self-test test done");
    wr(ADDR_PAIR01, 16'h4080);
    wr(ADDR_MODE, 16'h4000);
    wr(ADDR_SELFTEST, 16'h0008);
    wr(ADDR_OUTPUT, 16'h0000);
    wr(ADDR_MODE, 16'h4000);
    chk("locked", 24'h0, {capacitive_charge_state_o, normal_mode_o});
    wr(ADDR_SELFTEST, 16'h0008);
    wr(ADDR_MODE, 16'h4000);
    chk("normal", 24'h1, normal_mode_o);
    p = $urandom_range(3);
    e = 8'h3 << (2 * p);
    clr_seen();
    wr(7'(ADDR_PAIR01 + p), 16'h4080);
    chk("charge on", {e, e}, {capacitive_charge_state_o, seen[15:8]});
    wr(7'(ADDR_PAIR01 + p), 16'h2040);
    chk("charge off", {e, 8'h0}, {seen[7:0], capacitive_charge_state_o});
    wr(ADDR_MODE, 16'h8000);
    chk("no standby", 24'h1, {go_low_power_o, normal_mode_o});
    wr(ADDR_SELFTEST, 16'h0008);
    wr(ADDR_MODE, 16'h8000);
    chk("standby", 24'h1, go_low_power_o);
    $display("mode test done");
    wr(ADDR_PAGE, 16'h0004);
    rd(7'h3f);
    chk("page one", 24'h30000, {active_page_sel_o, rx[20], rx[15:1], 1'b0});
    wr(ADDR_PAGE, 16'h0000);
    chk("page zero", 24'h0, active_page_sel_o);
    $display("page test done");
    test_done();
  end
endmodule : osc_ctrl_regs_tb_top

`default_nettype wire

// File: sim/osc_spi_master.sv
// Behavioural serial master driving the link pins of the register bank.
// Assumes a 320 ns link clock, idle low, off-grid to the core clock.
`default_nettype none

module osc_spi_master (
  output logic sck_o,
  output logic csn_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sck_o = 1'b0;
    csn_o = 1'b1;
    sdi_o = 1'b0;
  end
  // Clock stands low outside frames; extra bits carry flipping junk
  task automatic xfer(input logic [23:0] f, input int n,
                      output logic [23:0] rx);
    #13 csn_o = 1'b0;
    #200;
    for (int i = 0; i < n; i++) begin
      sdi_o = (i < 24) ? f[23-i] : ~sdi_o;
      #160 sck_o = 1'b1;
      #159;
      if (i < 24) rx[23-i] = sdo_i;
      #1 sck_o = 1'b0;
    end
    #160 csn_o = 1'b1;
    sdi_o = ~sdi_o;
    #400;
  endtask : xfer
endmodule : osc_spi_master

`default_nettype wire

// File: verilog/osc_ctrl_regs.sv
// Serial-link control register bank of an eight channel switch controller.
// Assumes the serial clock idles low, data taken on its rising edge and
// shifted out after its falling edge, MSB first, chip select active low.
`default_nettype none

module osc_ctrl_regs (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic csn_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic spi_error_o,
  output logic normal_mode_o,
  output logic go_low_power_o,
  output logic active_page_sel_o,
  output logic watchdog_flip_bit_o,
  output logic [osc_pkg::CHANNELS-1:0] switch_stuck_selftest_go_o,
  output logic shadow_mem_selftest_go_o,
  output logic sense_chain_selftest_go_o,
  output logic converter_selftest_go_o,
  output logic [osc_pkg::CHANNELS-1:0] chan_output_on_o,
  output logic [osc_pkg::CHANNELS-1:0] direct_pin_ctrl_on_o,
  output logic [osc_pkg::CHANNELS-1:0] charge_mode_enter_o,
  output logic [osc_pkg::CHANNELS-1:0] charge_mode_leave_o,
  output logic [osc_pkg::CHANNELS-1:0] capacitive_charge_state_o,
  output logic [2*osc_pkg::CHANNELS-1:0] current_limit_sel_o,
  output logic [osc_pkg::CHANNELS-1:0] fine_sense_range_o
);
  import osc_pkg::*;

  localparam int unsigned N = CHANNELS;

  typedef struct packed {
    osc_frame_st_t st;
    logic sck_prev;
    logic csn_prev;
    logic [CNT_W-1:0] cnt;
    logic [FRAME_BITS-1:0] rx;
    logic [FRAME_BITS-1:0] tx;
    logic sdo;
    logic spi_err;
    logic page;
    logic normal;
    logic go_low_power;
    logic wdt;
    logic unlock;
    logic [N-1:0] stuck_go;
    logic shadow_go;
    logic sense_go;
    logic conv_go;
    logic [N-1:0] out_on;
    logic [N-1:0] din_on;
    logic [N-1:0] enter;
    logic [N-1:0] leave;
    logic [N-1:0] capacitive_charge_state;
    logic [2*N-1:0] limit;
    logic [N-1:0] fine;
  } osc_state_t;

  osc_state_t q, d;
  logic [2:0] pins;
  logic sck_f, csn_f, sdi_f;

  // Serial pins come from the master's clock domain
  osc_pin_sync #(
    .W(3),
    .IDLE(3'h2)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i({sck_i, csn_i, sdi_i}),
    .sync_o(pins)
  );

  assign sck_f = pins[2];
  assign csn_f = pins[1];
  assign sdi_f = pins[0];

  // Read view of one register; parity and unused bits are zero here
  function automatic logic [15:0] rd_word(input logic [6:0] a,
                                          input osc_state_t s);
    logic [15:0] w;
    int unsigned k;
    w = RST_WORD;
    k = 0;
    if (a == ADDR_PAGE || a == ADDR_PAGE_MIRROR) begin
      w[BIT_PAGE] = s.page;
    end else if (a == ADDR_MODE) begin
      w[BIT_GO_LOW_POWER] = s.go_low_power;
      w[BIT_NORMAL] = s.normal;
      w[BIT_WDT] = s.wdt;
    end else if (a == ADDR_SELFTEST) begin
      w[BIT_STUCK_LO +: N] = s.stuck_go;
      w[BIT_SHADOW_TEST] = s.shadow_go;
      w[BIT_SENSE_TEST] = s.sense_go;
      w[BIT_CONV_TEST] = s.conv_go;
      w[BIT_UNLOCK] = s.unlock;
      w[BIT_WDT] = s.wdt;
    end else if (a == ADDR_OUTPUT) begin
      w[BIT_OUT_LO +: N] = s.out_on;
      w[BIT_WDT] = s.wdt;
    end else if (a >= ADDR_PAIR01 && a <= ADDR_PAIR67) begin
      k = 2 * 32'(a - ADDR_PAIR01);
      w[EVEN_DIN] = s.din_on[k];
      w[EVEN_DIN + ODD_SHIFT] = s.din_on[k+1];
      w[EVEN_ENTER] = s.enter[k];
      w[EVEN_ENTER + ODD_SHIFT] = s.enter[k+1];
      w[EVEN_LEAVE] = s.leave[k];
      w[EVEN_LEAVE + ODD_SHIFT] = s.leave[k+1];
      w[EVEN_LIMIT_LO +: 2] = s.limit[2*k +: 2];
      w[EVEN_LIMIT_LO + ODD_SHIFT +: 2] = s.limit[2*k+2 +: 2];
      w[EVEN_FINE] = s.fine[k];
      w[EVEN_FINE + ODD_SHIFT] = s.fine[k+1];
      w[BIT_WDT] = s.wdt;
    end
    return w;
  endfunction : rd_word

  logic sck_rise, sck_fall, cs_fall, cs_rise;
  logic [1:0] op_now, op_end;
  logic [5:0] addr_now;
  logic [6:0] addr_end;
  logic [15:0] rdw, wd;
  logic [7:0] status;
  logic [4:0] idx;
  logic frame_ok;
  int unsigned k;

  always_comb begin
    d = q;
    k = 0;
    sck_rise = sck_f & ~q.sck_prev;
    sck_fall = ~sck_f & q.sck_prev;
    cs_fall = ~csn_f & q.csn_prev;
    cs_rise = csn_f & ~q.csn_prev;
    op_now = q.rx[6:5];
    addr_now = {q.rx[4:0], sdi_f};
    op_end = q.rx[23:22];
    addr_end = {q.page, q.rx[21:16]};
    wd = q.rx[15:0];
    status = {q.spi_err, q.normal, q.go_low_power, q.page, 4'h0};
    idx = 5'(FRAME_BITS - 1 - 32'(q.cnt));
    rdw = RST_WORD;
    // Parity over all 24 bits must come out odd
    frame_ok = (32'(q.cnt) == FRAME_BITS) && (^q.rx);

    d.sck_prev = sck_f;
    d.csn_prev = csn_f;
    // Trigger bits other than stuck_go last one cycle; no test engine lives here to hold them
    d.shadow_go = 1'b0;
    d.sense_go = 1'b0;
    d.conv_go = 1'b0;
    d.enter = '0;
    d.leave = '0;
    // Entry pulse wins over exit pulse in the same cycle
    d.capacitive_charge_state = (q.capacitive_charge_state & ~q.leave) | q.enter;

    unique case (q.st)
      OSC_IDLE: begin
        d.sdo = 1'b0;
        if (cs_fall) begin
          d.st = OSC_SHIFT;
          d.cnt = '0;
          d.tx = {status, RST_WORD};
          d.sdo = status[7];
        end
      end
      OSC_SHIFT: begin
        if (cs_rise) begin
          d.st = OSC_IDLE;
          d.sdo = 1'b0;
          d.unlock = 1'b0;
          d.spi_err = ~frame_ok;
          if (frame_ok && op_end == OP_WRITE) begin
            if (addr_end == ADDR_PAGE || addr_end == ADDR_PAGE_MIRROR) begin
              d.page = wd[BIT_PAGE];
            end else if (addr_end == ADDR_MODE) begin
              d.wdt = wd[BIT_WDT];
              if (q.unlock) begin
                d.normal = wd[BIT_NORMAL];
                d.go_low_power = wd[BIT_GO_LOW_POWER] & ~wd[BIT_NORMAL]
                                 & q.normal;
              end
            end else if (addr_end == ADDR_SELFTEST) begin
              d.wdt = wd[BIT_WDT];
              d.stuck_go = wd[BIT_STUCK_LO +: N];
              d.shadow_go = wd[BIT_SHADOW_TEST];
              d.sense_go = wd[BIT_SENSE_TEST];
              d.conv_go = wd[BIT_CONV_TEST];
              d.unlock = wd[BIT_UNLOCK];
            end else if (addr_end == ADDR_OUTPUT) begin
              d.wdt = wd[BIT_WDT];
              d.out_on = wd[BIT_OUT_LO +: N];
            end else if (addr_end >= ADDR_PAIR01 &&
                         addr_end <= ADDR_PAIR67) begin
              d.wdt = wd[BIT_WDT];
              k = 2 * 32'(addr_end - ADDR_PAIR01);
              d.din_on[k] = wd[EVEN_DIN];
              d.din_on[k+1] = wd[EVEN_DIN + ODD_SHIFT];
              d.enter[k] = wd[EVEN_ENTER] & q.normal;
              d.enter[k+1] = wd[EVEN_ENTER + ODD_SHIFT] & q.normal;
              d.leave[k] = wd[EVEN_LEAVE];
              d.leave[k+1] = wd[EVEN_LEAVE + ODD_SHIFT];
              d.limit[2*k +: 2] = wd[EVEN_LIMIT_LO +: 2];
              d.limit[2*k+2 +: 2] = wd[EVEN_LIMIT_LO + ODD_SHIFT +: 2];
              d.fine[k] = wd[EVEN_FINE];
              d.fine[k+1] = wd[EVEN_FINE + ODD_SHIFT];
            end
          end
        end else begin
          if (sck_rise) begin
            d.rx = {q.rx[FRAME_BITS-2:0], sdi_f};
            // Saturate so an overlong frame still counts as wrong
            if (&q.cnt == 1'b0) begin
              d.cnt = q.cnt + 1'b1;
            end
            if (32'(q.cnt) == 7) begin
              if (op_now == OP_ROM_READ) begin
                if (addr_now == ROM_ADDR_CAPABILITY) begin
                  rdw = {SERIAL_CAPABILITY, RST_BYTE};
                end
              end else begin
                rdw = rd_word({q.page, addr_now}, q);
              end
              // Odd parity over the whole answer, in its last bit
              d.tx[15:0] = {rdw[15:1],
                            ~^{q.tx[23:16], rdw[15:1]}};
            end
          end
          if (sck_fall) begin
            d.sdo = (32'(q.cnt) < FRAME_BITS) ? q.tx[idx] : 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= OSC_IDLE;
      q.sck_prev <= 1'b0;
      q.csn_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign sdo_o = q.sdo;
  assign sdo_oe_o = (q.st == OSC_SHIFT);
  assign spi_error_o = q.spi_err;
  assign normal_mode_o = q.normal;
  assign go_low_power_o = q.go_low_power;
  assign active_page_sel_o = q.page;
  assign watchdog_flip_bit_o = q.wdt;
  assign switch_stuck_selftest_go_o = q.stuck_go;
  assign shadow_mem_selftest_go_o = q.shadow_go;
  assign sense_chain_selftest_go_o = q.sense_go;
  assign converter_selftest_go_o = q.conv_go;
  assign chan_output_on_o = q.out_on;
  assign direct_pin_ctrl_on_o = q.din_on;
  assign charge_mode_enter_o = q.enter;
  assign charge_mode_leave_o = q.leave;
  assign capacitive_charge_state_o = q.capacitive_charge_state;
  assign current_limit_sel_o = q.limit;
  assign fine_sense_range_o = q.fine;
endmodule : osc_ctrl_regs

`default_nettype wire

// File: verilog/osc_pin_sync.sv
// Three-stage synchroniser with agreement filter for the serial pins.
// Assumes inputs arrive asynchronously to mclk_i.
`default_nettype none

module osc_pin_sync #(
  parameter int unsigned W = 3,
  parameter logic [W-1:0] IDLE = '0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } osc_sync_t;

  osc_sync_t q, d;
  logic [W-1:0] agree;

  always_comb begin
    d = q;
    d.s1 = async_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // Second and third stage must agree; a lone glitch is never taken
    agree = ~(q.s2 ^ q.s3);
    d.o = (agree & q.s3) | (~agree & q.o);
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= {IDLE, IDLE, IDLE, IDLE};
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.o;
endmodule : osc_pin_sync

`default_nettype wire
